// ### verilog/pmi_phy_mgmt.sv
// PHY indirect write port for the configuration loader, plus the access
// router of the emulated PHY (serial clause 22 and memory mapped views).
// Assumes the loader and host bus run on mclk; the register contents of
// the emulated PHY live outside and are reached through emu_* ports.
`include "pmi_cfg.svh"
module pmi_phy_mgmt (
    // System clock, 100 MHz.
    input wire logic mclk,
    // Asynchronous reset, active high.
    input wire logic rst,
    // Loader register port: write strobe, offset, data.
    input wire logic ldr_wr,
    input wire logic [11:0] ldr_addr,
    input wire logic [31:0] ldr_wdata,
    // Host bus access to the emulated PHY memory map.
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [11:0] host_addr,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    output logic host_hit,
    // Serial management transaction from the host MAC management registers.
    input wire logic ser_valid,
    input wire logic ser_write,
    input wire logic [4:0] ser_phy_addr,
    input wire logic [4:0] ser_reg_index,
    input wire logic [15:0] ser_wdata,
    output logic ser_ack,
    output logic [15:0] ser_rdata,
    // Strap-selected address of the emulated PHY, a pin.
    input wire logic [4:0] phy_addr_strap,
    // Management write command towards the PHY management engine.
    output pmi_pkg::pmi_mgmt_cmd_t mgmt_cmd,
    output logic mgmt_start,
    // Emulated PHY register file access and its read value.
    output pmi_pkg::pmi_emu_req_t emu_req,
    output pmi_pkg::pmi_emu_sel_t emu_sel,
    input wire logic [15:0] emu_rdata
);

    // Loader-only indirect data word.
    logic [15:0] write_data;
    // Strap synchroniser stages; only stage two feeds logic.
    logic [4:0] strap_meta;
    logic [4:0] strap_sync;
    // Combined request as presented to the decoder.
    pmi_pkg::pmi_emu_req_t next_req;
    // Whether the pending request came over the serial path.
    logic next_is_serial;
    logic req_is_serial;
    // Mapped offset decode result.
    logic host_in_map;

    // Offset within the emulated PHY block, as a word index.
    function automatic logic [4:0] map_index(input logic [11:0] a);
        // Distance from the block base in bytes.
        logic [11:0] d;
        d = a - `PMI_EMU_BASE;
        // Drop the byte lane bits, since each register takes one word.
        map_index = d[`PMI_MAP_IDX_HI:`PMI_MAP_IDX_LO];
    endfunction : map_index

    // True when a host address lies in the emulated PHY word range.
    function automatic logic in_map(input logic [11:0] a);
        // Distance from the block base in bytes.
        logic [11:0] d;
        d = a - `PMI_EMU_BASE;
        // Below the base the subtraction wraps, so the base is tested too.
        // Partial-word offsets are not registers and are left alone.
        in_map = (a >= `PMI_EMU_BASE) && (d < `PMI_EMU_SPAN)
            && ((d & `PMI_MAP_LANE_MASK) == '0);
    endfunction : in_map

    // Capture the data register; only the loader port can reach it, the
    // host bus has no path into this register at all.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            write_data <= `PMI_RST_DATA;
        end
        else if (ldr_wr && ldr_addr == `PMI_OFS_WRITE_DATA)
        begin
            write_data <= ldr_wdata[15:0];
        end
    end

    // A command write launches one PHY write using stored data. The
    // must-be-one bit is the loader's duty and is not checked here.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mgmt_cmd.phy_addr <= `PMI_RST_FIELD;
            mgmt_cmd.reg_index <= `PMI_RST_FIELD;
            mgmt_cmd.data <= `PMI_RST_DATA;
            mgmt_start <= 1'b0;
        end
        else
        begin
            mgmt_start <= 1'b0;
            if (ldr_wr && ldr_addr == `PMI_OFS_COMMAND)
            begin
                mgmt_cmd.phy_addr <=
                    ldr_wdata[`PMI_CMD_ADDR_HI:`PMI_CMD_ADDR_LO];
                mgmt_cmd.reg_index <=
                    ldr_wdata[`PMI_CMD_IDX_HI:`PMI_CMD_IDX_LO];
                // The port cannot carry a data write in this cycle, so stored data is used.
                mgmt_cmd.data <= (ldr_addr == `PMI_OFS_WRITE_DATA)
                    ? ldr_wdata[15:0] : write_data;
                mgmt_start <= 1'b1;
            end
        end
    end

    // Two flip-flops on the strap pin before any comparison.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            strap_meta <= `PMI_RST_FIELD;
            strap_sync <= `PMI_RST_FIELD;
        end
        else
        begin
            // Stage one is read by stage two only, never by other logic.
            strap_meta <= phy_addr_strap;
            strap_sync <= strap_meta;
        end
    end

    // Pick the access for this cycle: the serial path wins when both ask for this PHY.
    always_comb
    begin
        host_in_map = in_map(host_addr);
        next_req = '0;
        next_is_serial = 1'b0;
        // A serial request for our strap address takes priority.
        if (ser_valid && ser_phy_addr == strap_sync)
        begin
            next_req.valid = 1'b1;
            next_req.write = ser_write;
            next_req.reg_index = ser_reg_index;
            next_req.wdata = ser_wdata;
            next_is_serial = 1'b1;
        end
        // Otherwise a mapped access inside the block's word range.
        else if ((host_rd || host_wr) && host_in_map)
        begin
            next_req.valid = 1'b1;
            next_req.write = host_wr;
            next_req.reg_index = map_index(host_addr);
            next_req.wdata = host_wdata[15:0];
        end
    end

    // Register the selected access one cycle before the register file.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            emu_req <= '0;
            req_is_serial <= 1'b0;
        end
        else
        begin
            emu_req <= next_req;
            req_is_serial <= next_is_serial;
        end
    end

    // Index decode shared by both views.
    pmi_emu_decode u_decode (
        .reg_index(emu_req.reg_index),
        .sel(emu_sel)
    );

    // Return read data; unknown indices read zero on the serial path only, upper half padded.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ser_ack <= 1'b0;
            ser_rdata <= `PMI_ZERO16;
            host_hit <= 1'b0;
            host_rdata <= '0;
        end
        else
        begin
            ser_ack <= emu_req.valid && req_is_serial;
            host_hit <= emu_req.valid && !req_is_serial;
            // Serial answers carry only the 16-bit register value.
            if (emu_req.valid && req_is_serial)
            begin
                ser_rdata <= (emu_sel == pmi_pkg::PMI_SEL_NONE)
                    ? `PMI_ZERO16 : emu_rdata;
            end
            // Mapped answers pad the reserved upper half with zeros.
            if (emu_req.valid && !req_is_serial)
            begin
                host_rdata <= {`PMI_ZERO16, emu_rdata};
            end
        end
    end

endmodule : pmi_phy_mgmt

// ### verilog/pmi_cfg.svh
// Constants for the PHY indirect write port and emulated PHY index decode.
// Assumes inclusion by bare name from the design modules; the package does not include it.
`ifndef PMI_CFG_SVH
`define PMI_CFG_SVH

// Register offsets on the loader's private register port.
`define PMI_OFS_WRITE_DATA 12'h0a4
`define PMI_OFS_COMMAND 12'h0a8
// Command word field positions.
`define PMI_CMD_ADDR_HI 15
`define PMI_CMD_ADDR_LO 11
`define PMI_CMD_IDX_HI 10
`define PMI_CMD_IDX_LO 6
`define PMI_CMD_MUST_ONE 1
// Reset values of the stored fields.
`define PMI_RST_DATA 16'h0000
`define PMI_RST_FIELD 5'h00
// Emulated PHY serial register indices.
`define PMI_IDX_BASIC_CONTROL 5'h00
`define PMI_IDX_BASIC_STATUS 5'h01
`define PMI_IDX_IDENT_UPPER 5'h02
`define PMI_IDX_IDENT_LOWER 5'h03
`define PMI_IDX_AUTONEG_ADVERT 5'h04
`define PMI_IDX_PARTNER_ABILITY 5'h05
`define PMI_IDX_AUTONEG_EXPANSION 5'h06
`define PMI_IDX_SPECIAL_CTRL_STAT 5'h1f
// Memory map base of the emulated PHY; each register takes one word.
`define PMI_EMU_BASE 12'h1c0
// Byte span of the emulated PHY block: 32 words of 4 bytes.
`define PMI_EMU_SPAN 12'h080
// Word index bits of a byte offset within the block.
`define PMI_MAP_IDX_HI 6
`define PMI_MAP_IDX_LO 2
// Byte lane bits that must be zero for a whole-word access.
`define PMI_MAP_LANE_MASK 12'h003
`define PMI_ZERO16 16'h0000

`endif

// ### verilog/pmi_pkg.sv
// Types shared by the PHY indirect port and the emulated PHY decoder.
// Assumes pmi_cfg.svh is on the include path.
package pmi_pkg;

    // Management write command sent to the PHY management engine.
    typedef struct packed {
        logic [4:0] phy_addr;
        logic [4:0] reg_index;
        logic [15:0] data;
    } pmi_mgmt_cmd_t;

    // One emulated PHY register access, serial or memory mapped.
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] reg_index;
        logic [15:0] wdata;
    } pmi_emu_req_t;

    // Emulated PHY register selection after decode.
    typedef enum logic [3:0] {
        PMI_SEL_NONE,
        PMI_SEL_BASIC_CONTROL,
        PMI_SEL_BASIC_STATUS,
        PMI_SEL_IDENT_UPPER,
        PMI_SEL_IDENT_LOWER,
        PMI_SEL_AUTONEG_ADVERT,
        PMI_SEL_PARTNER_ABILITY,
        PMI_SEL_AUTONEG_EXPANSION,
        PMI_SEL_SPECIAL_CTRL_STAT
    } pmi_emu_sel_t;

endpackage : pmi_pkg

// ### verilog/pmi_emu_decode.sv
// Emulated PHY register index decoder, shared by serial and mapped paths.
// Assumes the caller owns the register contents; this only selects.
`include "pmi_cfg.svh"
module pmi_emu_decode (
    input wire logic [4:0] reg_index,
    output pmi_pkg::pmi_emu_sel_t sel
);

    // Map a clause 22 index onto one emulated register, or none.
    always_comb
    begin
        unique case (reg_index)
            `PMI_IDX_BASIC_CONTROL:
                sel = pmi_pkg::PMI_SEL_BASIC_CONTROL;
            `PMI_IDX_BASIC_STATUS: sel = pmi_pkg::PMI_SEL_BASIC_STATUS;
            `PMI_IDX_IDENT_UPPER: sel = pmi_pkg::PMI_SEL_IDENT_UPPER;
            `PMI_IDX_IDENT_LOWER: sel = pmi_pkg::PMI_SEL_IDENT_LOWER;
            `PMI_IDX_AUTONEG_ADVERT:
                sel = pmi_pkg::PMI_SEL_AUTONEG_ADVERT;
            `PMI_IDX_PARTNER_ABILITY:
                sel = pmi_pkg::PMI_SEL_PARTNER_ABILITY;
            `PMI_IDX_AUTONEG_EXPANSION:
                sel = pmi_pkg::PMI_SEL_AUTONEG_EXPANSION;
            `PMI_IDX_SPECIAL_CTRL_STAT:
                sel = pmi_pkg::PMI_SEL_SPECIAL_CTRL_STAT;
            // Any other index selects nothing.
            default: sel = pmi_pkg::PMI_SEL_NONE;
        endcase
    end

endmodule : pmi_emu_decode

// ### test/pmi_phy_mgmt_monitor.sv
// Checker for the PHY indirect write port and the emulated PHY paths.
// Assumes it is bound to pmi_phy_mgmt and the strap pin stays still.
module pmi_phy_mgmt_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ldr_wr,
    input wire logic [11:0] ldr_addr,
    input wire logic [31:0] ldr_wdata,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [11:0] host_addr,
    input wire logic [31:0] host_rdata,
    input wire logic host_hit,
    input wire logic ser_valid,
    input wire logic [4:0] ser_phy_addr,
    input wire logic ser_ack,
    input wire logic [15:0] ser_rdata,
    input wire logic [4:0] phy_addr_strap,
    input wire pmi_pkg::pmi_mgmt_cmd_t mgmt_cmd,
    input wire logic mgmt_start,
    input wire pmi_pkg::pmi_emu_req_t emu_req,
    input wire pmi_pkg::pmi_emu_sel_t emu_sel,
    input wire logic [15:0] emu_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Command write, serial request on our address, mapped request.
    wire cmd_wr = ldr_wr && ldr_addr == 12'h0a8;
    wire ser_hit = ser_valid && ser_phy_addr == phy_addr_strap;
    wire host_ok = (host_rd || host_wr) && !ser_valid && host_addr >= 12'h1c0
        && host_addr <= 12'h23c && host_addr[1:0] == 2'h0;
    // Copy of the stored write data, cleared by reset.
    logic [15:0] data_q;
    always_ff @(posedge mclk or posedge rst)
        if (rst) data_q <= 16'h0000;
        else if (ldr_wr && ldr_addr == 12'h0a4) data_q <= ldr_wdata[15:0];
    // Expected selection: indices 0 to 6 in order, then 31.
    function automatic pmi_pkg::pmi_emu_sel_t dec(input logic [4:0] i);
        if (i <= 5'h06) return pmi_pkg::pmi_emu_sel_t'(4'(i) + 4'h1);
        return i == 5'h1f ? pmi_pkg::PMI_SEL_SPECIAL_CTRL_STAT
            : pmi_pkg::PMI_SEL_NONE;
    endfunction : dec
    AST_CMD_START: assert property (cmd_wr |=> mgmt_start)
        else $error("command write gave no start");
    AST_START_CAUSE: assert property (mgmt_start |-> $past(cmd_wr))
        else $error("start without a loader command");
    AST_CMD_FIELDS: assert property (cmd_wr |=> mgmt_cmd ==
        {$past(ldr_wdata[15:6]), data_q}) else $error("bad command fields");
    AST_SER_PATH: assert property (ser_hit |=>
        emu_req.valid ##1 ser_ack) else $error("serial request not served");
    AST_SER_REFUSE: assert property (
        ser_valid && !ser_hit ##1 !ser_hit |=> !ser_ack)
        else $error("answer on a foreign address");
    AST_DECODE: assert property (
        emu_req.valid |-> emu_sel == dec(emu_req.reg_index))
        else $error("wrong index decode");
    AST_SER_DATA: assert property (ser_ack |-> ser_rdata ==
        ($past(emu_sel) == pmi_pkg::PMI_SEL_NONE
        ? 16'h0000 : $past(emu_rdata)))
        else $error("wrong serial read data");
    AST_HOST_WORD: assert property (host_hit |->
        host_rdata == {16'h0000, $past(emu_rdata)}) else $error("bad word");
    AST_HOST_HIT: assert property (host_ok |=> ##1 host_hit)
        else $error("mapped access not served");
endmodule : pmi_phy_mgmt_monitor
bind pmi_phy_mgmt pmi_phy_mgmt_monitor mon (.mclk, .rst, .ldr_wr, .ldr_addr,
    .ldr_wdata, .host_rd, .host_wr, .host_addr, .host_rdata, .host_hit,
    .ser_valid, .ser_phy_addr, .ser_ack, .ser_rdata, .phy_addr_strap,
    .mgmt_cmd, .mgmt_start, .emu_req, .emu_sel, .emu_rdata);

// ### test/pmi_emu_model.sv
// Register contents of the emulated PHY behind the emu_* ports.
// Assumes the selection is decoded from the standing request.
module pmi_emu_model (
    input wire logic mclk,
    input wire logic rst,
    input wire pmi_pkg::pmi_emu_req_t emu_req,
    input wire pmi_pkg::pmi_emu_sel_t emu_sel,
    output logic [15:0] emu_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // No selection reads as noise, so a missing zero fill shows up.
    logic [15:0] mem [9];
    assign emu_rdata = emu_sel == pmi_pkg::PMI_SEL_NONE ? 16'hdead
        : mem[emu_sel];
    // Writes land on the edge after the request; unknown ones are lost.
    always_ff @(posedge mclk or posedge rst)
        if (rst) mem <= '{default: 16'h0000};
        else if (emu_req.valid && emu_req.write && emu_sel != 4'h0)
            mem[emu_sel] <= emu_req.wdata;
endmodule : pmi_emu_model

// ### test/pmi_phy_mgmt_tb.sv
// Self-checking bench for the indirect write port and emulated PHY.
// Assumes the checker is bound in and the strap pin is fixed.
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module pmi_phy_mgmt_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, ldr_wr, host_rd, host_wr, ser_valid, ser_write;
    logic host_hit, ser_ack, mgmt_start;
    logic [11:0] ldr_addr, host_addr;
    logic [31:0] ldr_wdata, host_wdata, host_rdata, r;
    logic [4:0] ser_phy_addr, ser_reg_index, strap;
    logic [15:0] ser_wdata, ser_rdata, emu_rdata, dlast;
    pmi_pkg::pmi_mgmt_cmd_t mgmt_cmd;
    pmi_pkg::pmi_emu_req_t emu_req;
    pmi_pkg::pmi_emu_sel_t emu_sel;
    int n_mismatch = 0, check_count = 0, seed = 32'h32c5e269;
    logic [15:0] model [32];
    pmi_phy_mgmt dut (.mclk, .rst, .ldr_wr, .ldr_addr, .ldr_wdata, .host_rd,
        .host_wr, .host_addr, .host_wdata, .host_rdata, .host_hit, .ser_valid,
        .ser_write, .ser_phy_addr, .ser_reg_index, .ser_wdata, .ser_ack,
        .ser_rdata, .phy_addr_strap(strap), .mgmt_cmd, .mgmt_start, .emu_req,
        .emu_sel, .emu_rdata);
    pmi_emu_model emu (.mclk, .rst, .emu_req, .emu_sel, .emu_rdata);
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic bit known(input logic [4:0] i);
        return i <= 5'h06 || i == 5'h1f;
    endfunction : known
    // One loader beat; the strobe stays up for back-to-back beats.
    task automatic ldr(input logic [11:0] a, input logic [31:0] d);
        {ldr_wr, ldr_addr, ldr_wdata} = {1'b1, a, d};
        @(negedge mclk);
    endtask : ldr
    // Serial access; the answer is looked at two edges later.
    task automatic ser(bit w, logic [4:0] pa, logic [4:0] i, logic [15:0] d);
        {ser_valid, ser_write, ser_phy_addr, ser_reg_index} = {1'b1, w, pa, i};
        ser_wdata = d;
        @(negedge mclk);
        ser_valid = 1'b0;
        @(negedge mclk);
        `CHK(ser_ack, pa == strap)
        if (pa == strap && !w)
            `CHK(ser_rdata, known(i) ? model[i] : 16'h0)
        if (pa == strap && w && known(i)) model[i] = d;
    endtask : ser
    // Mapped access to one word of the emulated PHY.
    task automatic host(bit w, logic [4:0] i, logic [15:0] d);
        {host_rd, host_wr, host_addr} = {!w, w, 12'h1c0 + {5'h00, i, 2'h0}};
        host_wdata = {16'($random(seed)), d};
        @(negedge mclk);
        {host_rd, host_wr} = 2'b00;
        @(negedge mclk);
        `CHK(host_hit, 1'b1)
        if (!w) `CHK(host_rdata, {16'h0000, model[i]})
        else model[i] = d;
    endtask : host
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    initial
    begin
        {ldr_wr, host_rd, host_wr, ser_valid, ser_write, rst} = 6'h01;
        {ldr_addr, host_addr, ldr_wdata, host_wdata} = '0;
        {ser_phy_addr, ser_reg_index, ser_wdata, dlast} = '0;
        strap = 5'h0b;
        model = '{default: 16'h0000};
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        // First command uses the reset data; odd rounds reload it.
        for (int k = 0; k < 12; k++)
        begin
            r = $random(seed);
            if (k % 2 == 1)
            begin
                dlast = r[15:0];
                ldr(12'h0a4, r);
            end
            r = $random(seed) | 32'h2;
            ldr(k == 5 ? 12'h0ac : 12'h0a8, r);
            ldr_wr = 1'b0;
            `CHK(mgmt_start, k != 5)
            if (k != 5) `CHK(mgmt_cmd, {r[15:11], r[10:6], dlast})
            @(negedge mclk);
        end
        // The host bus must not reach the command register.
        {host_wr, host_addr, host_wdata} = {1'b1, 12'h0a8, 32'h0000ffc2};
        @(negedge mclk);
        host_wr = 1'b0;
        `CHK(mgmt_start, 1'b0)
        @(negedge mclk);
        `CHK(host_hit, 1'b0)
        // Mixed mapped and serial traffic against the shared model.
        for (int k = 0; k < 150; k++)
        begin
            r = $random(seed);
            if (r[31])
                host(r[30], r[2:0] == 3'h7 ? 5'h1f : {2'h0, r[2:0]}, r[15:0]);
            else
                ser(r[30], r[29] ? strap : r[20:16],
                    r[25:21] & {{2{r[28]}}, 3'h7}, r[15:0]);
        end
        give_verdict();
    end
    // Watchdog; the run needs well under 1000 cycles.
    initial
    begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
endmodule : pmi_phy_mgmt_tb
